// ==== hw/ar_cfg.svh ====
`ifndef AR_CFG_SVH
`define AR_CFG_SVH

`define AR_CLK_MHZ        40
`define AR_TICK_US        10000
`define AR_TICK_CYCLES    (`AR_TICK_US * `AR_CLK_MHZ)
`define AR_TICK_W         15
`define AR_DS_TICKS       10
`define AR_START_MAX_CS   9'h1f4
`define AR_DEAD_MIN_DS    12'h002
`define AR_TIME_MAX_DS    12'hbb8
`define AR_ALARM_NONE     8'h00
`define AR_ALARM_FIRST    8'h28
`define AR_ALARM_SECOND   8'h29
`define AR_ILK_OFF        2'h0
`define AR_ILK_ON         2'h1
`define AR_ILK_RSVD       2'h2
`define AR_CFG_FREE       1'h0
`define AR_SHOTS          5
`define AR_REQS           3
`define AR_OBJECTS        16

`endif

// ==== hw/ar_pkg.sv ====
`include "ar_cfg.svh"
package ar_pkg;
	typedef logic [8:0]            cs_t;
	typedef logic [11:0]           ds_t;
	typedef logic [`AR_TICK_W-1:0] ticks_t;
	typedef logic [7:0]            alarm_sel_t;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_START  = 5'h02,
		ST_DEAD   = 5'h04,
		ST_RECLM  = 5'h08,
		ST_FINAL  = 5'h10
	} seq_state_e;

	typedef struct packed {
		logic [31:0] pre;
		ticks_t      count;
		logic        running;
	} tmr_s;

	typedef struct packed {
		seq_state_e                 state;
		logic [1:0]                 src;
		logic [2:0]                 shot;
		logic [`AR_REQS-1:0]        req_prev;
		logic [`AR_REQS-1:0]        final_latch;
		logic                       reclose_cmd;
		logic                       final_trip;
		logic                       alarm_first;
		logic                       alarm_second;
		logic [`AR_OBJECTS-1:0]     indicator;
		logic                       breaker_closed;
		logic                       interlock_on;
		logic                       setting_fault;
	} seq_s;
endpackage

// ==== hw/ar_timer_if.sv ====
interface ar_timer_if;
	import ar_pkg::*;
	logic   load;
	ticks_t load_ticks;
	logic   expired;
	modport seq (output load, output load_ticks, input expired);
	modport tmr (input load, input load_ticks, output expired);
endinterface

// ==== hw/ar_tick_timer.sv ====
`include "ar_cfg.svh"
module ar_tick_timer
	import ar_pkg::*;
#(
	parameter int TICK_CYCLES = `AR_TICK_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	ar_timer_if.tmr   tmr
);
	if (TICK_CYCLES < 1) begin : g_chk
		$error("tick period must be at least one cycle");
	end

	tmr_s r_reg;
	tmr_s r_next;
	logic tick;

	// Countdown in 10 ms ticks; a load restarts the prescaler
	always_comb begin
		r_next = r_reg;
		tick = (r_reg.pre == 32'(TICK_CYCLES - 1));
		r_next.pre = tick ? 32'h0 : r_reg.pre + 32'h1;
		if (tmr.load) begin
			r_next.pre = 32'h0;
			r_next.count = tmr.load_ticks;
			r_next.running = 1'b1;
		end else if (r_reg.running) begin
			if (r_reg.count == '0)
				r_next.running = 1'b0;
			else if (tick)
				r_next.count = r_reg.count - 1'b1;
		end
	end

	// Not gated by load: the sequencer reloads in the cycle it sees expiry
	assign tmr.expired = r_reg.running && (r_reg.count == '0);

	always_ff @(posedge sys_clk) begin
		if (rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end
endmodule

// ==== hw/auto_reclose_sequencer_config.sv ====
// Notes on behaviour
// - Per shot, request A enable: 0 inhibits the shot, 1 lets A start it.
// - Per shot, separate enables for requests B and C start the shot.
// - Shots started by B or C first wait a start delay of 0 to 5 s.
// - Each shot keeps breaker open a dead time of 0.2 to 300 s.
// - Per request, final-trip enable decides if the sequence ends tripping.
// - Final trip of each request waits its own time of 0 to 300 s.
// - In-progress alarm selector: 0 none, 40 first output, 41 second.
// - Per request final-trip alarm selector with the same encoding.
// - Object word: indicator-used flag; polarity shows open (0) or closed (1).
// - Object word type flag: 0 other object, 1 circuit breaker.
// - Interlock selector: 0 off, 1 on (only while configuration selector is 0), 2 reserved and unused.
// - Configuration selector 0 picks the free program; 1 is reserved.
`include "ar_cfg.svh"
module auto_reclose_sequencer_config
	import ar_pkg::*;
#(
	parameter int TICK_CYCLES = `AR_TICK_CYCLES,
	parameter int N_OBJ       = `AR_OBJECTS
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        reclose_request_a,
	input  wire logic                        reclose_request_b,
	input  wire logic                        reclose_request_c,
	input  wire logic [`AR_SHOTS-1:0]        shot_en_a,
	input  wire logic [`AR_SHOTS-1:0]        shot_en_b,
	input  wire logic [`AR_SHOTS-1:0]        shot_en_c,
	input  wire cs_t  [`AR_SHOTS-1:0]        start_delay_b,
	input  wire cs_t  [`AR_SHOTS-1:0]        start_delay_c,
	input  wire ds_t  [`AR_SHOTS-1:0]        dead_time,
	input  wire logic [`AR_REQS-1:0]         final_en,
	input  wire ds_t  [`AR_REQS-1:0]         final_time,
	input  wire ds_t                         reclaim_time,
	input  wire logic                        auto_reclose_function,
	input  wire logic                        interrupt_cmd,
	input  wire alarm_sel_t                  progress_alarm_sel,
	input  wire alarm_sel_t [`AR_REQS-1:0]   final_alarm_sel,
	input  wire logic [N_OBJ-1:0]            obj_used,
	input  wire logic [N_OBJ-1:0]            obj_polarity,
	input  wire logic [N_OBJ-1:0]            obj_is_breaker,
	input  wire logic [N_OBJ-1:0]            obj_closed,
	input  wire logic [1:0]                  interlock_sel,
	input  wire logic                        config_sel,
	output logic                             reclose_cmd,
	output logic                             final_trip,
	output logic                             in_progress,
	output logic [2:0]                       active_shot,
	output logic                             alarm_output_first,
	output logic                             alarm_output_second,
	output logic [`AR_REQS-1:0]              final_tripped,
	output logic [N_OBJ-1:0]                 obj_indicator,
	output logic                             breaker_closed,
	output logic                             interlock_on,
	output logic                             setting_fault
);
	if (N_OBJ != `AR_OBJECTS) begin : g_chk
		$error("object count must be 16");
	end

	ar_timer_if tif ();

	ar_tick_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tmr     (tif.tmr)
	);

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic ticks_t ds_ticks(input ds_t v, input ds_t lo);
		ds_t c;
		c = (v < lo) ? lo : ((v > `AR_TIME_MAX_DS) ? `AR_TIME_MAX_DS : v);
		return ticks_t'(c) * ticks_t'(`AR_DS_TICKS);
	endfunction

	// Lowest enabled shot strictly after 'from'; from = 7 searches all
	function automatic logic [3:0] next_shot(input logic [`AR_SHOTS-1:0] m,
	                                         input logic [2:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = `AR_SHOTS - 1; i >= 0; i--) begin
			if (m[i] && ((from == 3'h7) || (3'(i) > from)))
				r = 4'(i);
		end
		return r;
	endfunction

	function automatic logic route(input alarm_sel_t s, input alarm_sel_t o,
	                               input logic act);
		return act && (s == o);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Sequencer

	seq_s r_reg;
	seq_s r_next;

	logic [`AR_REQS-1:0]  req_now;
	logic [`AR_REQS-1:0]  rise;
	logic [1:0]           new_src;
	logic [1:0]           use_src;
	logic [`AR_SHOTS-1:0] mask;
	logic [3:0]           nxt;
	logic                 go_shot;
	logic                 busy;
	cs_t                  sd;

	always_comb begin
		r_next = r_reg;
		req_now = {reclose_request_c, reclose_request_b, reclose_request_a};
		rise = req_now & ~r_reg.req_prev;
		new_src = rise[0] ? 2'h0 : (rise[1] ? 2'h1 : 2'h2);
		use_src = r_reg.src;
		mask = '0;
		nxt = 4'h8;
		go_shot = 1'b0;
		sd = '0;
		tif.load = 1'b0;
		tif.load_ticks = '0;
		r_next.req_prev = req_now;
		r_next.reclose_cmd = 1'b0;
		r_next.final_trip = 1'b0;

		if ((r_reg.state == ST_IDLE || r_reg.state == ST_RECLM)
		    && (|rise)) begin
			use_src = new_src;
			unique case (new_src)
				2'h0:    mask = shot_en_a;
				2'h1:    mask = shot_en_b;
				default: mask = shot_en_c;
			endcase
			nxt = next_shot(mask,
				(r_reg.state == ST_IDLE) ? 3'h7 : r_reg.shot);
			go_shot = 1'b1;
		end

		unique case (r_reg.state)
			ST_START: if (tif.expired) begin
				r_next.state = ST_DEAD;
				tif.load = 1'b1;
				tif.load_ticks = ds_ticks(dead_time[r_reg.shot],
					`AR_DEAD_MIN_DS);
			end
			ST_DEAD: if (tif.expired) begin
				r_next.reclose_cmd = 1'b1;
				r_next.state = ST_RECLM;
				tif.load = 1'b1;
				tif.load_ticks = ds_ticks(reclaim_time, `AR_DEAD_MIN_DS);
			end
			ST_RECLM: if (!go_shot && tif.expired)
				r_next.state = ST_IDLE;
			ST_FINAL: if (tif.expired) begin
				r_next.final_trip = 1'b1;
				r_next.final_latch[r_reg.src] = 1'b1;
				r_next.state = ST_IDLE;
			end
			default: ;
		endcase

		if (go_shot) begin
			r_next.src = use_src;
			if (r_reg.state == ST_IDLE)
				r_next.final_latch = '0;
			if (nxt != 4'h8) begin
				r_next.shot = nxt[2:0];
				tif.load = 1'b1;
				if (use_src == 2'h0) begin
					r_next.state = ST_DEAD;
					tif.load_ticks = ds_ticks(dead_time[nxt[2:0]],
						`AR_DEAD_MIN_DS);
				end else begin
					sd = (use_src == 2'h1) ? start_delay_b[nxt[2:0]]
					                       : start_delay_c[nxt[2:0]];
					r_next.state = ST_START;
					tif.load_ticks = ticks_t'((sd > `AR_START_MAX_CS)
						? `AR_START_MAX_CS : sd);
				end
			end else if (final_en[use_src]) begin
				r_next.state = ST_FINAL;
				tif.load = 1'b1;
				tif.load_ticks = ds_ticks(final_time[use_src], 12'h000);
			end else begin
				r_next.state = ST_IDLE;
			end
		end

		if (interrupt_cmd || !auto_reclose_function) begin
			r_next.state = ST_IDLE;
			r_next.reclose_cmd = 1'b0;
			r_next.final_trip = 1'b0;
			tif.load = 1'b0;
			if (interrupt_cmd)
				r_next.final_latch = '0;
		end

		busy = (r_next.state != ST_IDLE);
		r_next.alarm_first = route(progress_alarm_sel, `AR_ALARM_FIRST,
			busy);
		r_next.alarm_second = route(progress_alarm_sel, `AR_ALARM_SECOND,
			busy);
		for (int i = 0; i < `AR_REQS; i++) begin
			r_next.alarm_first = r_next.alarm_first
				| route(final_alarm_sel[i], `AR_ALARM_FIRST,
				        r_next.final_latch[i]);
			r_next.alarm_second = r_next.alarm_second
				| route(final_alarm_sel[i], `AR_ALARM_SECOND,
				        r_next.final_latch[i]);
		end

		r_next.indicator = obj_used
			& ~(obj_polarity ^ obj_closed);
		r_next.breaker_closed = |(obj_is_breaker & obj_closed);
		r_next.interlock_on = (interlock_sel == `AR_ILK_ON)
			&& (config_sel == `AR_CFG_FREE);
		r_next.setting_fault = (interlock_sel > `AR_ILK_ON)
			|| (config_sel != `AR_CFG_FREE);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign reclose_cmd         = r_reg.reclose_cmd;
	assign final_trip          = r_reg.final_trip;
	assign in_progress         = (r_reg.state != ST_IDLE);
	assign active_shot         = r_reg.shot;
	assign alarm_output_first  = r_reg.alarm_first;
	assign alarm_output_second = r_reg.alarm_second;
	assign final_tripped       = r_reg.final_latch;
	assign obj_indicator       = r_reg.indicator;
	assign breaker_closed      = r_reg.breaker_closed;
	assign interlock_on        = r_reg.interlock_on;
	assign setting_fault       = r_reg.setting_fault;
endmodule

// ==== dv/ar_remote_master.sv ====
module ar_remote_master (
	input  wire logic sys_clk,
	output logic      in_use,
	output logic      interrupt_cmd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		in_use = 1'b1;
		interrupt_cmd = 1'b0;
	end
	// Switch the reclose function in or out of use
	task set_use(input logic u);
		@(posedge sys_clk) in_use <= u;
	endtask
	// One-cycle write of the interruption command
	task interrupt();
		@(posedge sys_clk) interrupt_cmd <= 1'b1;
		@(posedge sys_clk) interrupt_cmd <= 1'b0;
	endtask
endmodule

// ==== dv/ar_seq_chk.sv ====
`include "ar_cfg.svh"
module ar_seq_chk
	import ar_pkg::*;
(
	input wire logic                 sys_clk,
	input wire logic                 rst,
	input wire logic                 reclose_request_a,
	input wire logic [`AR_SHOTS-1:0] shot_en_a,
	input wire logic                 auto_reclose_function,
	input wire logic                 interrupt_cmd,
	input wire alarm_sel_t           progress_alarm_sel,
	input wire logic [1:0]           interlock_sel,
	input wire logic                 config_sel,
	input wire logic                 reclose_cmd,
	input wire logic                 final_trip,
	input wire logic                 in_progress,
	input wire logic [2:0]           active_shot,
	input wire logic                 alarm_output_first,
	input wire logic [`AR_REQS-1:0]  final_tripped,
	input wire logic                 interlock_on,
	input wire logic                 setting_fault
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_rise_a;
		!reclose_request_a ##1 reclose_request_a;
	endsequence
	sequence s_ready_a;
		!in_progress && auto_reclose_function && !interrupt_cmd && shot_en_a[0];
	endsequence
	chk_start_a: assert property (s_rise_a ##0 s_ready_a |=>
		in_progress && active_shot == 3'h0) else $error("shot one not begun");
	chk_cmd_pulse: assert property (reclose_cmd |=> !reclose_cmd)
		else $error("reclose command too long");
	chk_trip_pulse: assert property (final_trip |=> !final_trip)
		else $error("final trip too long");
	chk_final_latch: assert property (final_trip && !interrupt_cmd |=>
		final_tripped != 3'h0) else $error("final trip not latched");
	chk_abort_idle: assert property (interrupt_cmd |=> !in_progress)
		else $error("abort ignored");
	chk_off_idle: assert property (!auto_reclose_function |=> !in_progress)
		else $error("busy while out of use");
	chk_alarm_route: assert property ((in_progress &&
		progress_alarm_sel == `AR_ALARM_FIRST) [*2] |-> alarm_output_first)
		else $error("progress alarm missing");
	chk_ilk_map: assert property (!$past(rst) |-> interlock_on ==
		($past(interlock_sel) == 2'h1 && !$past(config_sel)))
		else $error("interlock state wrong");
	chk_fault_map: assert property (!$past(rst) |-> setting_fault ==
		($past(interlock_sel) >= 2'h2 || $past(config_sel)))
		else $error("setting fault wrong");
endmodule
bind auto_reclose_sequencer_config ar_seq_chk i_chk (
	.sys_clk               (sys_clk),
	.rst                   (rst),
	.reclose_request_a     (reclose_request_a),
	.shot_en_a             (shot_en_a),
	.auto_reclose_function (auto_reclose_function),
	.interrupt_cmd         (interrupt_cmd),
	.progress_alarm_sel    (progress_alarm_sel),
	.interlock_sel         (interlock_sel),
	.config_sel            (config_sel),
	.reclose_cmd           (reclose_cmd),
	.final_trip            (final_trip),
	.in_progress           (in_progress),
	.active_shot           (active_shot),
	.alarm_output_first    (alarm_output_first),
	.final_tripped         (final_tripped),
	.interlock_on          (interlock_on),
	.setting_fault         (setting_fault)
);

// ==== dv/auto_reclose_sequencer_config_tb.sv ====
`include "ar_cfg.svh"
module auto_reclose_sequencer_config_tb
	import ar_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                       sys_clk, rst, in_use, intr, cfg, cmd, trip, busy;
	logic                       al1, al2, brk, ilk_on, fault;
	logic [2:0]                 req, fen, shot, ftd;
	logic [`AR_SHOTS-1:0]       ena, enb, enc;
	cs_t  [`AR_SHOTS-1:0]       sdb, sdc;
	ds_t  [`AR_SHOTS-1:0]       dead;
	ds_t  [`AR_REQS-1:0]        ftime;
	ds_t                        reclaim;
	alarm_sel_t                 pal;
	alarm_sel_t [`AR_REQS-1:0]  fal;
	logic [15:0]                used, pol, isb, clo, ind;
	logic [1:0]                 ilk;
	int                         bad_count, cmp_count, n;

	auto_reclose_sequencer_config #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk),
		.rst(rst), .reclose_request_a(req[0]), .reclose_request_b(req[1]),
		.reclose_request_c(req[2]), .shot_en_a(ena), .shot_en_b(enb),
		.shot_en_c(enc), .start_delay_b(sdb), .start_delay_c(sdc),
		.dead_time(dead), .final_en(fen), .final_time(ftime),
		.reclaim_time(reclaim), .auto_reclose_function(in_use),
		.interrupt_cmd(intr), .progress_alarm_sel(pal), .final_alarm_sel(fal),
		.obj_used(used), .obj_polarity(pol), .obj_is_breaker(isb),
		.obj_closed(clo), .interlock_sel(ilk), .config_sel(cfg),
		.reclose_cmd(cmd), .final_trip(trip), .in_progress(busy),
		.active_shot(shot), .alarm_output_first(al1),
		.alarm_output_second(al2), .final_tripped(ftd), .obj_indicator(ind),
		.breaker_closed(brk), .interlock_on(ilk_on), .setting_fault(fault));
	ar_remote_master i_master (.sys_clk(sys_clk), .in_use(in_use),
		.interrupt_cmd(intr));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic c, input string m);
		cmp_count++;
		if (c !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// Raise one request for a cycle; returns at the edge that takes it
	task fire(input int i);
		@(posedge sys_clk) req[i] <= 1'b1;
		@(posedge sys_clk) req[i] <= 1'b0;
	endtask
	// Cycles until reclose (0), final trip (1) or idle (2), up to lim
	task wait_on(input int w, input int lim);
		for (n = 1; n < lim; n++) begin
			step(1);
			if ((w == 0 && cmd === 1'b1) || (w == 1 && trip === 1'b1) ||
				(w == 2 && busy === 1'b0))
				break;
		end
	endtask
	task stop_test();
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_shot_a();
		ena <= 5'h01;
		pal <= 8'h28;
		fire(0);
		step(2);
		chk(busy === 1'b1 && shot === 3'h0 && al1 === 1'b1, "a start");
		wait_on(0, 300);
		chk(n >= 78 && n <= 86, "dead time");
		wait_on(2, 300);
		chk(n >= 78 && n <= 86, "reclaim end");
	endtask
	task t_shot_b();
		enb <= 5'h02;
		sdb[1] <= 9'h005;
		fire(1);
		wait_on(0, 300);
		chk(n >= 98 && n <= 110 && shot === 3'h1, "b start delay");
		wait_on(2, 300);
		chk(n >= 78 && n <= 86, "b reclaim end");
	endtask
	task t_reclaim_c();
		pal <= 8'h29;
		enc <= 5'h05;
		sdc[0] <= 9'h003;
		fire(2);
		wait_on(0, 300);
		chk(n >= 90 && n <= 100 && shot === 3'h0, "c start delay");
		chk(al2 === 1'b1 && al1 === 1'b0, "progress alarm second");
		fire(2);
		step(2);
		chk(busy === 1'b1 && shot === 3'h2, "next shot in reclaim");
		wait_on(0, 300);
		chk(n >= 76 && n <= 84 && shot === 3'h2, "next shot dead");
		wait_on(2, 300);
		chk(n >= 78 && n <= 86, "c reclaim end");
	endtask
	task t_final_c();
		enc <= 5'h00;
		fen <= 3'h4;
		ftime[2] <= 12'h001;
		fal[2] <= 8'h29;
		fire(2);
		wait_on(1, 300);
		chk(n >= 38 && n <= 46, "final trip time");
		step(2);
		chk(ftd === 3'h4 && al2 === 1'b1, "final alarm");
		i_master.interrupt();
		step(2);
		chk(ftd === 3'h0 && al2 === 1'b0, "latch cleared");
	endtask
	task t_abort();
		dead[0] <= 12'h00a;
		fire(0);
		step(10);
		i_master.interrupt();
		step(2);
		chk(busy === 1'b0, "abort");
		wait_on(0, 500);
		chk(n == 500, "no reclose after abort");
		i_master.set_use(1'b0);
		fire(0);
		step(3);
		chk(busy === 1'b0, "out of use");
		i_master.set_use(1'b1);
	endtask
	task t_static();
		used <= 16'h000f;
		pol <= 16'h0005;
		clo <= 16'h0003;
		isb <= 16'h0002;
		step(3);
		chk(ind === 16'h0009, "indicators");
		chk(brk === 1'b1, "breaker");
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk);
			ilk <= k[1:0];
			cfg <= k[2];
			step(3);
			chk(ilk_on === (k[1:0] == 2'h1 && !k[2]), "interlock");
			chk(fault === (k[1:0] >= 2'h2 || k[2]), "config");
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, req, fen, ena, enb, enc, sdb, sdc, ftime, fal} = '1;
		{req, fen, ena, enb, enc, sdb, sdc, ftime, fal, pal} = '0;
		{used, pol, isb, clo, ilk, cfg} = '0;
		dead = {`AR_SHOTS{12'h002}};
		reclaim = 12'h002;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		step(2);
		t_shot_a();
		t_shot_b();
		t_reclaim_c();
		t_final_c();
		t_abort();
		t_static();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		stop_test();
	end
endmodule
